//--- shared/msd_pkg.sv
package msd_pkg;
   // address and data widths of both spaces
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] SPACE_FIRST = 16'h0000;
   localparam logic [ADDR_W-1:0] SPACE_LAST = 16'hFFFF;
   localparam logic [ADDR_W-1:0] PTR_RESET = 16'h0000;
   localparam logic [ADDR_W-1:0] PTR_STEP = 16'h0001;
   // byte lanes of a bus address
   localparam int LO_MSB = 7;
   localparam int HI_LSB = 8;
   localparam int HI_MSB = 15;
   // machine cycle of four input clocks
   localparam int CLK_PERIOD_NS = 100;
   localparam int CLKS_PER_MC = 4;
   localparam int PH_W = 2;
   localparam logic [PH_W-1:0] PH_ALE = 2'h0;
   localparam logic [PH_W-1:0] PH_HOLD = 2'h1;
   localparam logic [PH_W-1:0] PH_STRB = 2'h2;
   localparam logic [PH_W-1:0] PH_LAST = 2'h3;
   localparam logic [PH_W-1:0] PH_STEP = 2'h1;
   // cycles for read data to pass the pin synchroniser
   localparam int TAIL_W = 2;
   localparam logic [TAIL_W-1:0] TAIL_FIRST = 2'h0;
   localparam logic [TAIL_W-1:0] TAIL_LAST = 2'h1;
   localparam logic [TAIL_W-1:0] TAIL_STEP = 2'h1;
   localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] BYTE_IDLE = 8'hFF;
   // access kinds; none of them writes program space
   typedef enum logic [1:0] {
      KIND_FETCH,
      KIND_CODE_READ,
      KIND_DATA_READ,
      KIND_DATA_WRITE
   } msd_kind_t;
endpackage : msd_pkg

//--- shared/msd_phase_if.sv
`timescale 1ns/100ps
interface msd_phase_if;
   logic [msd_pkg::PH_W-1:0] phase;
   modport gen (output phase);
   modport use_ph (input phase);
endinterface : msd_phase_if

//--- core/msd_cycle_gen.sv
`timescale 1ns/100ps
module msd_cycle_gen
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // phase of the machine cycle
   msd_phase_if.gen ph
);
   import msd_pkg::*;

   logic [PH_W-1:0] phase_ff;
   logic [PH_W-1:0] nxt_phase;

   always_comb
   begin
      if (phase_ff == PH_LAST)
         nxt_phase = PH_ALE;
      else
         nxt_phase = phase_ff + PH_STEP;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         phase_ff <= PH_ALE;
      else
         phase_ff <= nxt_phase;
   end

   assign ph.phase = phase_ff;
endmodule : msd_cycle_gen

//--- core/msd_ext_bus_top.sv
// Summary of operation
// - sixteen-bit fetch pointer advances after each fetch
// - separate 64KB program and data spaces
// - port 0 multiplexes address, data; port 2 high address
// - on-chip range internal, above it external
// - romless variant sends everything external
// - no write path into program space
// - data space only via external data move
// - on-chip program limit changes at run time
// - machine cycle four clocks, strobes from it
`timescale 1ns/100ps
module msd_ext_bus_top
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // configuration levels
   input wire logic romless,
   input wire logic onchip_prog_en,
   input wire logic [msd_pkg::ADDR_W-1:0] onchip_program_limit,
   input wire logic onchip_data_en,
   input wire logic [msd_pkg::ADDR_W-1:0] onchip_data_limit,
   // fetch pointer control
   input wire logic ptr_load,
   input wire logic [msd_pkg::ADDR_W-1:0] ptr_load_value,
   output logic [msd_pkg::ADDR_W-1:0] next_fetch_pointer,
   // access request from the core
   input wire logic req_valid,
   input wire msd_pkg::msd_kind_t req_kind,
   input wire logic [msd_pkg::ADDR_W-1:0] req_addr,
   input wire logic [msd_pkg::DATA_W-1:0] req_wdata,
   output logic req_busy,
   output logic req_done,
   output logic [msd_pkg::DATA_W-1:0] req_rdata,
   // internal memory port
   output logic int_sel,
   output logic int_data_space,
   output logic int_we,
   output logic [msd_pkg::ADDR_W-1:0] int_addr,
   output logic [msd_pkg::DATA_W-1:0] int_wdata,
   input wire logic [msd_pkg::DATA_W-1:0] int_rdata,
   // external bus pins
   input wire logic [msd_pkg::DATA_W-1:0] port0_in,
   output logic [msd_pkg::DATA_W-1:0] port0_out,
   output logic port0_oe,
   output logic [msd_pkg::DATA_W-1:0] port2_out,
   output logic ale,
   output logic program_store_strobe_n,
   output logic data_rd_n,
   output logic data_wr_n
);
   import msd_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_EXT,
      ST_TAIL,
      ST_INT_SEL,
      ST_INT_TAKE
   } msd_state_t;

   msd_phase_if ph_if ();

   msd_cycle_gen i_msd_cycle_gen
   (
      .clk (clk),
      .rst_n (rst_n),
      .ph (ph_if.gen)
   );

   msd_state_t state_ff, nxt_state;
   msd_kind_t kind_ff, nxt_kind;
   logic [TAIL_W-1:0] tail_ff, nxt_tail;
   logic [ADDR_W-1:0] ptr_ff, nxt_ptr;
   logic [ADDR_W-1:0] addr_ff, nxt_addr;
   logic [DATA_W-1:0] wdata_ff, nxt_wdata;
   logic [DATA_W-1:0] rdata_ff, nxt_rdata;
   logic busy_ff, nxt_busy;
   logic done_ff, nxt_done;
   logic int_sel_ff, nxt_int_sel;
   logic int_data_ff, nxt_int_data;
   logic int_we_ff, nxt_int_we;
   logic [DATA_W-1:0] p0_out_ff, nxt_p0_out;
   logic p0_oe_ff, nxt_p0_oe;
   logic [DATA_W-1:0] p2_out_ff, nxt_p2_out;
   logic ale_ff, nxt_ale;
   logic pss_n_ff, nxt_pss_n;
   logic rd_n_ff, nxt_rd_n;
   logic wr_n_ff, nxt_wr_n;
   logic [DATA_W-1:0] p0_sync1_ff, p0_sync2_ff;

   logic [ADDR_W-1:0] acc_addr;
   logic acc_is_data;
   logic acc_internal;
   logic take;

   // pins are asynchronous to clk
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         p0_sync1_ff <= BYTE_ZERO;
         p0_sync2_ff <= BYTE_ZERO;
      end
      else
      begin
         p0_sync1_ff <= port0_in;
         p0_sync2_ff <= p0_sync1_ff;
      end
   end

   always_comb
   begin
      acc_is_data = (req_kind == KIND_DATA_READ) ||
                    (req_kind == KIND_DATA_WRITE);
      if (req_kind == KIND_FETCH)
         acc_addr = ptr_ff;
      else
         acc_addr = req_addr;
      if (romless)
         acc_internal = 1'b0;
      else if (acc_is_data)
         acc_internal = onchip_data_en && (acc_addr <= onchip_data_limit);
      else
         acc_internal = onchip_prog_en &&
                        (acc_addr <= onchip_program_limit);
      // accesses start only on a machine cycle boundary
      take = req_valid && !busy_ff && (state_ff == ST_IDLE) &&
             (ph_if.phase == PH_LAST);
   end

   always_comb
   begin
      nxt_state = state_ff;
      nxt_kind = kind_ff;
      nxt_tail = tail_ff;
      nxt_ptr = ptr_ff;
      nxt_addr = addr_ff;
      nxt_wdata = wdata_ff;
      nxt_rdata = rdata_ff;
      nxt_busy = busy_ff;
      nxt_done = 1'b0;
      nxt_int_sel = 1'b0;
      nxt_int_data = int_data_ff;
      nxt_int_we = 1'b0;
      nxt_p0_out = p0_out_ff;
      nxt_p0_oe = p0_oe_ff;
      nxt_p2_out = p2_out_ff;
      nxt_ale = 1'b0;
      nxt_pss_n = pss_n_ff;
      nxt_rd_n = rd_n_ff;
      nxt_wr_n = wr_n_ff;
      case (state_ff)
         ST_IDLE:
         begin
            if (take)
            begin
               nxt_kind = req_kind;
               nxt_addr = acc_addr;
               nxt_wdata = req_wdata;
               nxt_busy = 1'b1;
               if (acc_internal)
               begin
                  nxt_state = ST_INT_SEL;
                  nxt_int_sel = 1'b1;
                  nxt_int_data = acc_is_data;
                  nxt_int_we = (req_kind == KIND_DATA_WRITE);
               end
               else
               begin
                  nxt_state = ST_EXT;
                  nxt_p0_out = acc_addr[LO_MSB:0];
                  nxt_p0_oe = 1'b1;
                  nxt_ale = 1'b1;
                  nxt_p2_out = acc_addr[HI_MSB:HI_LSB];
               end
            end
         end
         ST_EXT:
         begin
            case (ph_if.phase)
               PH_ALE:
               begin
                  // address stays on port 0 one phase past the latch
                  nxt_ale = 1'b0;
               end
               PH_HOLD:
               begin
                  case (kind_ff)
                     KIND_FETCH, KIND_CODE_READ:
                     begin
                        nxt_pss_n = 1'b0;
                        nxt_p0_oe = 1'b0;
                     end
                     KIND_DATA_READ:
                     begin
                        nxt_rd_n = 1'b0;
                        nxt_p0_oe = 1'b0;
                     end
                     KIND_DATA_WRITE:
                     begin
                        nxt_wr_n = 1'b0;
                        nxt_p0_out = wdata_ff;
                        nxt_p0_oe = 1'b1;
                     end
                     default:
                     begin
                        nxt_p0_oe = 1'b0;
                     end
                  endcase
               end
               PH_LAST:
               begin
                  nxt_pss_n = 1'b1;
                  nxt_rd_n = 1'b1;
                  nxt_wr_n = 1'b1;
                  nxt_p0_oe = 1'b0;
                  nxt_p0_out = BYTE_IDLE;
                  nxt_tail = TAIL_FIRST;
                  nxt_state = ST_TAIL;
               end
               default:
               begin
                  nxt_state = ST_EXT;
               end
            endcase
         end
         ST_TAIL:
         begin
            // waits for the last strobe phase to leave the synchroniser
            if (tail_ff == TAIL_LAST)
            begin
               nxt_rdata = p0_sync2_ff;
               nxt_done = 1'b1;
               nxt_busy = 1'b0;
               nxt_state = ST_IDLE;
            end
            else
               nxt_tail = tail_ff + TAIL_STEP;
         end
         ST_INT_SEL:
         begin
            nxt_state = ST_INT_TAKE;
         end
         ST_INT_TAKE:
         begin
            nxt_rdata = int_rdata;
            nxt_done = 1'b1;
            nxt_busy = 1'b0;
            nxt_state = ST_IDLE;
         end
         default:
         begin
            nxt_state = ST_IDLE;
            nxt_busy = 1'b0;
         end
      endcase
      if (ptr_load)
         nxt_ptr = ptr_load_value;
      else if (nxt_done && (kind_ff == KIND_FETCH))
         nxt_ptr = ptr_ff + PTR_STEP;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff <= ST_IDLE;
         kind_ff <= KIND_FETCH;
         tail_ff <= TAIL_FIRST;
         ptr_ff <= PTR_RESET;
         addr_ff <= SPACE_FIRST;
         wdata_ff <= BYTE_ZERO;
         rdata_ff <= BYTE_ZERO;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         int_sel_ff <= 1'b0;
         int_data_ff <= 1'b0;
         int_we_ff <= 1'b0;
         p0_out_ff <= BYTE_IDLE;
         p0_oe_ff <= 1'b0;
         p2_out_ff <= BYTE_IDLE;
         ale_ff <= 1'b0;
         pss_n_ff <= 1'b1;
         rd_n_ff <= 1'b1;
         wr_n_ff <= 1'b1;
      end
      else
      begin
         state_ff <= nxt_state;
         kind_ff <= nxt_kind;
         tail_ff <= nxt_tail;
         ptr_ff <= nxt_ptr;
         addr_ff <= nxt_addr;
         wdata_ff <= nxt_wdata;
         rdata_ff <= nxt_rdata;
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
         int_sel_ff <= nxt_int_sel;
         int_data_ff <= nxt_int_data;
         int_we_ff <= nxt_int_we;
         p0_out_ff <= nxt_p0_out;
         p0_oe_ff <= nxt_p0_oe;
         p2_out_ff <= nxt_p2_out;
         ale_ff <= nxt_ale;
         pss_n_ff <= nxt_pss_n;
         rd_n_ff <= nxt_rd_n;
         wr_n_ff <= nxt_wr_n;
      end
   end

   assign next_fetch_pointer = ptr_ff;
   assign req_busy = busy_ff;
   assign req_done = done_ff;
   assign req_rdata = rdata_ff;
   assign int_sel = int_sel_ff;
   assign int_data_space = int_data_ff;
   assign int_we = int_we_ff;
   assign int_addr = addr_ff;
   assign int_wdata = wdata_ff;
   assign port0_out = p0_out_ff;
   assign port0_oe = p0_oe_ff;
   assign port2_out = p2_out_ff;
   assign ale = ale_ff;
   assign program_store_strobe_n = pss_n_ff;
   assign data_rd_n = rd_n_ff;
   assign data_wr_n = wr_n_ff;
endmodule : msd_ext_bus_top

//--- testbench/msd_ext_mem_model.sv
`timescale 1ns/100ps
module msd_ext_mem_model
(
   // bus pins of the controller
   input wire logic clk,
   input wire logic ale,
   input wire logic program_store_strobe_n,
   input wire logic data_rd_n,
   input wire logic data_wr_n,
   input wire logic [7:0] port0_out,
   input wire logic [7:0] port2_out,
   output logic [7:0] port0_in
);
   logic [7:0] lo_ff = 8'h00;
   logic [7:0] last_ff = 8'h00;
   logic [7:0] dmem [0:65535];
   logic [15:0] a;
   assign a = {port2_out, lo_ff};
   always @(posedge clk)
      if (ale)
         lo_ff <= port0_out;
   always @(posedge clk)
      if (!data_wr_n)
         dmem[a] <= port0_out;
   always_comb
      if (!program_store_strobe_n)
         port0_in = a[7:0] ^ a[15:8] ^ 8'h5A;
      else if (!data_rd_n)
         port0_in = dmem[a];
      else
         port0_in = ~last_ff;
   // released bus keeps toggling so stale data never passes
   always @(posedge clk)
      last_ff <= port0_in;
endmodule : msd_ext_mem_model

//--- testbench/msd_ext_bus_top_chk.sv
`timescale 1ns/100ps
module msd_ext_bus_top_chk
(
   // watched ports
   input wire logic clk,
   input wire logic rst_n,
   input wire logic romless,
   input wire logic req_done,
   input wire logic int_sel,
   input wire logic int_data_space,
   input wire logic int_we,
   input wire logic [7:0] port0_out,
   input wire logic port0_oe,
   input wire logic ale,
   input wire logic program_store_strobe_n,
   input wire logic data_rd_n,
   input wire logic data_wr_n
);
   logic any_low;
   assign any_low = !program_store_strobe_n || !data_rd_n || !data_wr_n;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence two_low;
      any_low [*2] ##1 !any_low;
   endsequence
   chk_ale_one_cycle: assert property (
      ale |-> port0_oe ##1 !ale && $stable(port0_out))
      else $error("ale pulse or address hold wrong");
   chk_strobe_after_ale: assert property (ale |-> ##2 two_low)
      else $error("strobe not two cycles after ale");
   chk_ext_done: assert property ($rose(ale) |-> ##6 req_done)
      else $error("external access done late");
   chk_rd_release: assert property ($fell(data_rd_n) |-> !port0_oe)
      else $error("port0 driven during data read");
   chk_wr_drive: assert property (
      !data_wr_n |-> port0_oe && program_store_strobe_n)
      else $error("data write not driven");
   chk_romless_ext: assert property (romless |-> !int_sel)
      else $error("internal access while romless");
   chk_int_done: assert property (int_sel |-> !ale ##2 req_done)
      else $error("internal access timing wrong");
   chk_no_prog_write: assert property (
      int_we |-> int_sel && int_data_space)
      else $error("write into program space");
endmodule : msd_ext_bus_top_chk
bind msd_ext_bus_top msd_ext_bus_top_chk i_msd_ext_bus_top_chk (.clk, .rst_n,
   .romless, .req_done, .int_sel, .int_data_space, .int_we, .port0_out,
   .port0_oe, .ale, .program_store_strobe_n, .data_rd_n, .data_wr_n);

//--- testbench/tb_msd_ext_bus_top.sv
`timescale 1ns/100ps
module tb_msd_ext_bus_top;
   import msd_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, romless = 1'b1, onchip_prog_en = 1'b0;
   logic onchip_data_en = 1'b0, ptr_load = 1'b0, req_valid = 1'b0;
   logic [15:0] onchip_program_limit = 16'h3FFF, ptr_load_value = 16'h0000;
   logic [15:0] onchip_data_limit = 16'h03FF, req_addr = 16'h0000;
   logic [15:0] next_fetch_pointer, int_addr;
   msd_kind_t req_kind = KIND_FETCH;
   logic [7:0] req_wdata = 8'h00, req_rdata, int_wdata, int_rdata, rd;
   logic [7:0] port0_in, port0_out, port2_out;
   logic req_busy, req_done, int_sel, int_data_space, int_we, port0_oe;
   logic ale, program_store_strobe_n, data_rd_n, data_wr_n;
   int num_errors = 0, comparisons = 0, n_ale, n_int, n_we;
   assign int_rdata = int_addr[7:0] ^ 8'hC3;
   msd_ext_bus_top i_msd_ext_bus_top (.clk, .rst_n, .romless, .onchip_prog_en,
      .onchip_program_limit, .onchip_data_en, .onchip_data_limit, .ptr_load,
      .ptr_load_value, .next_fetch_pointer, .req_valid, .req_kind, .req_addr,
      .req_wdata, .req_busy, .req_done, .req_rdata, .int_sel, .int_data_space,
      .int_we, .int_addr, .int_wdata, .int_rdata, .port0_in, .port0_out,
      .port0_oe, .port2_out, .ale, .program_store_strobe_n, .data_rd_n,
      .data_wr_n);
   msd_ext_mem_model i_msd_ext_mem_model (.clk, .ale, .program_store_strobe_n,
      .data_rd_n, .data_wr_n, .port0_out, .port2_out, .port0_in);
   initial
      forever #50 clk = ~clk;
   always @(posedge clk)
   begin
      n_ale += ale;
      n_int += int_sel;
      n_we += int_we;
   end
   function automatic logic [7:0] pv(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction : pv
   task check(input string nm, input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   // caller sits just after a rising edge
   task access(input msd_kind_t k, input logic [15:0] a, input logic [7:0] wd);
      int n;
      n = 0;
      req_kind = k;
      req_addr = a;
      req_wdata = wd;
      req_valid = 1'b1;
      n_ale = 0;
      n_int = 0;
      n_we = 0;
      while (req_busy !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         #10;
         n++;
      end
      req_valid = 1'b0;
      while (req_done !== 1'b1 && n < 40)
      begin
         @(posedge clk);
         #10;
         n++;
      end
      check("access done", req_done, 16'h0001);
      rd = req_rdata;
   endtask : access
   task t_fetch;
      check("reset pointer", next_fetch_pointer, 16'h0000);
      ptr_load_value = 16'hFFFF;
      ptr_load = 1'b1;
      @(posedge clk);
      #10;
      ptr_load = 1'b0;
      access(KIND_FETCH, 16'h0000, 8'h00);
      check("fetch data", rd, pv(16'hFFFF));
      check("ale count", n_ale, 1);
      check("high byte", port2_out, 8'hFF);
      check("wrapped pointer", next_fetch_pointer, 16'h0000);
      access(KIND_FETCH, 16'h0000, 8'h00);
      check("fetch data", rd, pv(16'h0000));
      check("pointer", next_fetch_pointer, 16'h0001);
      $display("test fetch done");
   endtask : t_fetch
   // written byte differs from the program pattern at the same address
   task t_data;
      access(KIND_DATA_WRITE, 16'hABCD, 8'hA5);
      access(KIND_DATA_READ, 16'hABCD, 8'h00);
      check("data read", rd, 8'hA5);
      check("high byte", port2_out, 8'hAB);
      access(KIND_CODE_READ, 16'hABCD, 8'h00);
      check("code read", rd, pv(16'hABCD));
      check("internal count", n_int, 0);
      $display("test data done");
   endtask : t_data
   task t_limit;
      romless = 1'b0;
      onchip_prog_en = 1'b1;
      access(KIND_CODE_READ, 16'h3FFF, 8'h00);
      check("internal count", n_int, 1);
      check("internal data", rd, 8'h3C);
      check("write strobe count", n_we, 0);
      check("data space", int_data_space, 1'b0);
      access(KIND_CODE_READ, 16'h4000, 8'h00);
      check("ale count", n_ale, 1);
      check("code read", rd, pv(16'h4000));
      onchip_program_limit = 16'h4FFF;
      access(KIND_CODE_READ, 16'h4000, 8'h00);
      check("internal count", n_int, 1);
      onchip_prog_en = 1'b0;
      access(KIND_CODE_READ, 16'h0010, 8'h00);
      check("ale count", n_ale, 1);
      onchip_prog_en = 1'b1;
      romless = 1'b1;
      access(KIND_CODE_READ, 16'h0010, 8'h00);
      check("ale count", n_ale, 1);
      $display("test limit done");
   endtask : t_limit
   task t_internal;
      romless = 1'b0;
      onchip_data_en = 1'b1;
      access(KIND_DATA_WRITE, 16'h0123, 8'h96);
      check("internal count", n_int, 1);
      check("write strobe count", n_we, 1);
      check("data space", int_data_space, 1'b1);
      check("internal address", int_addr, 16'h0123);
      check("internal wdata", int_wdata, 8'h96);
      access(KIND_DATA_READ, 16'h03FF, 8'h00);
      check("internal data", rd, 8'h3C);
      check("write strobe count", n_we, 0);
      access(KIND_DATA_WRITE, 16'h0400, 8'h69);
      check("ale count", n_ale, 1);
      check("write strobe count", n_we, 0);
      ptr_load_value = 16'h0005;
      ptr_load = 1'b1;
      @(posedge clk);
      #10;
      ptr_load = 1'b0;
      access(KIND_FETCH, 16'h0000, 8'h00);
      check("data space", int_data_space, 1'b0);
      check("internal fetch", rd, 8'hC6);
      check("pointer", next_fetch_pointer, 16'h0006);
      $display("test internal done");
   endtask : t_internal
   task wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up
   // about 100 cycles of traffic; generous margin
   initial
   begin
      #300000;
      num_errors++;
      wrap_up;
   end
   initial
   begin
      repeat (10) @(posedge clk);
      #10;
      rst_n = 1'b1;
      t_fetch;
      t_data;
      t_limit;
      t_internal;
      wrap_up;
   end
endmodule : tb_msd_ext_bus_top
